// [rtl/gfei_regs.vh]
// Register map and field constants for the falling-edge GPIO interrupt block.
// Assumes a 32-bit AXI4-Lite slave port with 8-bit byte addresses.
`ifndef GFEI_REGS_VH
`define GFEI_REGS_VH

// ----------------------------------------------------------------------------
// Address layout: byte address = {group[2:0], word[2:0], 2'b00}
// ----------------------------------------------------------------------------
`define GFEI_ADDR_W 8
`define GFEI_GRP_HI 7
`define GFEI_GRP_LO 5
`define GFEI_WORD_HI 4
`define GFEI_WORD_LO 2

// Register groups, five words each (banks 0/1, 2/3, 4/5, 6/7, 8)
`define GFEI_GRP_FALL_SET 3'h0
`define GFEI_GRP_FALL_CLR 3'h1
`define GFEI_GRP_PENDING 3'h2
`define GFEI_GRP_RISE_SET 3'h3
`define GFEI_GRP_RISE_CLR 3'h4
`define GFEI_GRP_IRQ_EN 3'h5
`define GFEI_GRP_IRQ_CLR 3'h6
`define GFEI_GRP_LAST 3'h6

// Word index inside a group
`define GFEI_NUM_WORDS 3'h5
`define GFEI_LAST_WORD 3'h4

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define GFEI_BANK_W 16
`define GFEI_NUM_BANKS 9
`define GFEI_PIN_W 144
`define GFEI_WIDE_W 160
`define GFEI_PAD_W 16
`define GFEI_WORD_SHIFT 5'h00
`define GFEI_FULL_WORD_MASK 32'hffffffff
`define GFEI_LAST_WORD_MASK 32'h0000ffff

// Reset values
`define GFEI_RST_ENABLE 160'h0
`define GFEI_RST_BANK 16'h0000
`define GFEI_RST_WORD 32'h00000000

// AXI response codes
`define GFEI_RESP_OKAY 2'h0
`define GFEI_RESP_SLVERR 2'h2

`endif

// [rtl/gfei_edge_bank.v]
// One bank of sixteen pins: synchroniser, edge detector and pending flags.
// Assumes pins are asynchronous to core_clk_i and enables come from the
// register file on the same clock.
`timescale 1ns/1ns

`include "gfei_regs.vh"

module gfei_edge_bank
(
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Pins from outside the clock domain
    input wire [15:0] pin_i,
    // Per-pin enables and write-one clear strobes
    input wire [15:0] fall_en_i,
    input wire [15:0] rise_en_i,
    input wire [15:0] clr_i,
    // Pending flags
    output wire [15:0] pending_o
);

    reg [15:0] pin_meta_reg;
    reg [15:0] pin_sync_reg;
    reg [15:0] pin_prev_reg;
    reg [15:0] pending_reg;
    reg [15:0] pending_next;
    wire [15:0] fall_hit;
    wire [15:0] rise_hit;

    // ------------------------------------------------------------------------
    // Synchroniser and previous-level store
    // ------------------------------------------------------------------------
    // The first stage feeds only the second; edges compare stage two and three
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_meta_reg <= `GFEI_RST_BANK;
            pin_sync_reg <= `GFEI_RST_BANK;
            pin_prev_reg <= `GFEI_RST_BANK;
        end
        else
        begin
            pin_meta_reg <= pin_i;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Enabled edges only; both enables reset low so a pin high at reset is harmless
    assign fall_hit = fall_en_i & pin_prev_reg & ~pin_sync_reg;
    assign rise_hit = rise_en_i & ~pin_prev_reg & pin_sync_reg;

    // ------------------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------------------
    // A new edge in the clearing cycle survives the clear
    always @*
    begin
        pending_next = (pending_reg & ~clr_i) | fall_hit | rise_hit;
    end

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            pending_reg <= `GFEI_RST_BANK;
        else
            pending_reg <= pending_next;
    end

    assign pending_o = pending_reg;

endmodule

// [rtl/gfei_top.v]
// Falling/rising edge interrupt enables and pending flags for 144 GPIO pins
// in nine banks of sixteen, reached over an AXI4-Lite slave port.
// Assumes one 25 MHz clock, synchronous active-low reset, asynchronous pins.
// Rise enables and the interrupt enable share the falling-edge layout.
// Unmapped addresses answer SLVERR and change nothing.
// Pins may change at any time; each bank synchronises its own.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns

`include "gfei_regs.vh"

module gfei_top
(
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // GPIO pins, bank k pin j at bit 16*k+j
    input wire [143:0] gpio_pins_i,
    // AXI4-Lite write address channel
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    // AXI4-Lite write data channel
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    // AXI4-Lite write response channel
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // AXI4-Lite read address channel
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    // AXI4-Lite read data channel
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // Interrupt
    output wire irq_o
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    // Enables kept 160 bits wide so every word is one part-select;
    // bits 159:144 are never written and stay zero
    reg [159:0] fall_en_reg;
    reg [159:0] fall_en_next;
    reg [159:0] rise_en_reg;
    reg [159:0] rise_en_next;
    reg [159:0] irq_en_reg;
    reg [159:0] irq_en_next;
    reg [159:0] pend_clr;

    // Write channel capture
    reg aw_got_reg;
    reg w_got_reg;
    reg [7:0] waddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;

    // Read channel
    reg rvalid_reg;
    reg [31:0] rdata_reg;
    reg [1:0] rresp_reg;
    // Read answer chosen from the live address
    reg [31:0] rdata_next;
    reg [1:0] rresp_next;

    // Registered interrupt level
    reg irq_reg;

    // Pending flags from the banks, then padded to the enable width
    wire [143:0] pend_pins;
    wire [159:0] pend_wide;

    // ------------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------------
    // Decode of the held write; nothing here looks at the live bus
    wire wr_fire;
    wire [2:0] wgrp;
    wire [2:0] wword;
    wire wr_ok;
    wire [31:0] wbyte_mask;
    wire [31:0] wword_mask;
    wire [31:0] wbits;
    wire [7:0] wshift;
    wire [159:0] wide_bits;

    // Both halves held and no response outstanding
    assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
    assign wgrp = waddr_reg[`GFEI_GRP_HI:`GFEI_GRP_LO];
    assign wword = waddr_reg[`GFEI_WORD_HI:`GFEI_WORD_LO];
    assign wr_ok = (wgrp <= `GFEI_GRP_LAST) && (wword < `GFEI_NUM_WORDS);

    // Byte lanes from wstrb; the last word only carries bank 8
    assign wbyte_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                         {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign wword_mask = (wword == `GFEI_LAST_WORD) ? `GFEI_LAST_WORD_MASK
                                                   : `GFEI_FULL_WORD_MASK;
    assign wbits = wdata_reg & wbyte_mask & wword_mask;
    // Word w covers bits 32w+31:32w, even bank low, odd bank high
    assign wshift = {wword, `GFEI_WORD_SHIFT};
    assign wide_bits = {128'h0, wbits} << wshift;

    // ------------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------------
    // Set and clear groups only ever touch the bits written as one
    // The interrupt-enable group is plain read/write, masked by byte lane
    always @*
    begin
        fall_en_next = fall_en_reg;
        rise_en_next = rise_en_reg;
        irq_en_next = irq_en_reg;
        pend_clr = `GFEI_RST_ENABLE;
        // Only a mapped write, in its firing cycle, changes anything
        if (wr_fire && wr_ok)
        begin
            if (wgrp == `GFEI_GRP_FALL_SET)
                fall_en_next = fall_en_reg | wide_bits;
            else if (wgrp == `GFEI_GRP_FALL_CLR)
                fall_en_next = fall_en_reg & ~wide_bits;
            else if (wgrp == `GFEI_GRP_RISE_SET)
                rise_en_next = rise_en_reg | wide_bits;
            else if (wgrp == `GFEI_GRP_RISE_CLR)
                rise_en_next = rise_en_reg & ~wide_bits;
            else if (wgrp == `GFEI_GRP_IRQ_EN)
                irq_en_next = (irq_en_reg & ~({128'h0, wbyte_mask & wword_mask} << wshift))
                              | wide_bits;
            // Pending group and its write-only alias both clear flags
            else
                pend_clr = wide_bits;
        end
    end

    // Enable registers
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            fall_en_reg <= `GFEI_RST_ENABLE;
            rise_en_reg <= `GFEI_RST_ENABLE;
            irq_en_reg <= `GFEI_RST_ENABLE;
        end
        else
        begin
            fall_en_reg <= fall_en_next;
            rise_en_reg <= rise_en_next;
            irq_en_reg <= irq_en_next;
        end
    end

    // ------------------------------------------------------------------------
    // Pin banks
    // ------------------------------------------------------------------------
    // One synchroniser, edge detector and flag set per bank of sixteen
    genvar g;
    generate
        for (g = 0; g < `GFEI_NUM_BANKS; g = g + 1)
        begin : bank
            gfei_edge_bank u_bank
            (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .pin_i(gpio_pins_i[g*`GFEI_BANK_W +: `GFEI_BANK_W]),
                .fall_en_i(fall_en_reg[g*`GFEI_BANK_W +: `GFEI_BANK_W]),
                .rise_en_i(rise_en_reg[g*`GFEI_BANK_W +: `GFEI_BANK_W]),
                .clr_i(pend_clr[g*`GFEI_BANK_W +: `GFEI_BANK_W]),
                .pending_o(pend_pins[g*`GFEI_BANK_W +: `GFEI_BANK_W])
            );
        end
    endgenerate

    // Upper pad keeps the high half of the bank 8 word reading zero
    assign pend_wide = {{`GFEI_PAD_W{1'b0}}, pend_pins};

    // ------------------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------------------
    // Address and data are taken in either order; nothing new is taken
    // until the response has gone, so one write at a time
    assign s_axi_awready_o = ~aw_got_reg & ~bvalid_reg;
    assign s_axi_wready_o = ~w_got_reg & ~bvalid_reg;

    // Capture each half as it arrives; release both when the write fires
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= `GFEI_RST_WORD;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `GFEI_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_got_reg <= 1'b1;
                waddr_reg <= s_axi_awaddr_i;
            end
            else if (wr_fire)
            begin
                aw_got_reg <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
            end
            else if (wr_fire)
            begin
                w_got_reg <= 1'b0;
            end
            // Response rises at the same edge at which the write takes effect
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? `GFEI_RESP_OKAY : `GFEI_RESP_SLVERR;
            end
            else if (s_axi_bready_i)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Response outputs come straight from flops
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------
    // Read fields come from the live address: the data is latched at the
    // address handshake, so the answer stands one cycle later
    wire [2:0] rgrp;
    wire [2:0] rword;
    wire [7:0] rshift;
    wire rd_ok;

    assign rgrp = s_axi_araddr_i[`GFEI_GRP_HI:`GFEI_GRP_LO];
    assign rword = s_axi_araddr_i[`GFEI_WORD_HI:`GFEI_WORD_LO];
    assign rshift = {rword, `GFEI_WORD_SHIFT};
    assign rd_ok = (rgrp <= `GFEI_GRP_LAST) && (rword < `GFEI_NUM_WORDS);

    // Set and clear views return the same enable state; the clear-only
    // group reads zero; bits above bank 8 are zero by construction
    always @*
    begin
        rdata_next = `GFEI_RST_WORD;
        rresp_next = `GFEI_RESP_OKAY;
        if (!rd_ok)
            rresp_next = `GFEI_RESP_SLVERR;
        else if (rgrp == `GFEI_GRP_FALL_SET || rgrp == `GFEI_GRP_FALL_CLR)
            rdata_next = fall_en_reg[rshift +: 32];
        else if (rgrp == `GFEI_GRP_PENDING)
            rdata_next = pend_wide[rshift +: 32];
        else if (rgrp == `GFEI_GRP_RISE_SET || rgrp == `GFEI_GRP_RISE_CLR)
            rdata_next = rise_en_reg[rshift +: 32];
        else if (rgrp == `GFEI_GRP_IRQ_EN)
            rdata_next = irq_en_reg[rshift +: 32];
        else
            rdata_next = `GFEI_RST_WORD;
    end

    // ------------------------------------------------------------------------
    // Read channels
    // ------------------------------------------------------------------------
    // One read at a time: arready drops while data waits
    assign s_axi_arready_o = ~rvalid_reg;

    // Data is latched at the handshake, so later state changes cannot
    // alter an answer that waits; reads never change state themselves
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= `GFEI_RST_WORD;
            rresp_reg <= `GFEI_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rdata_next;
                rresp_reg <= rresp_next;
            end
            else if (s_axi_rready_i)
            begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Read answer from flops; it stands until the master takes it
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;

    // ------------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------------
    // Registered so the pin never glitches while flags and enables change
    // Costs one cycle of latency against a combinational output
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(pend_wide & irq_en_reg);
    end

    // Level output: high until software clears the flag or its enable
    assign irq_o = irq_reg;

endmodule

// [testbench/gfei_chk_checker.sv]
// Checker for the edge interrupt block: bus handshakes, reads, reset state.
// Assumes it is bound into gfei_top and sees only its ports, one clock.
`timescale 1ns/1ns
`include "gfei_regs.vh"
module gfei_chk
(
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Write side of the register bus
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire [1:0] s_axi_bresp_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // Read side of the register bus
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    input wire [1:0] s_axi_rresp_o,
    input wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // Interrupt
    input wire irq_o
);
// ----------------------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------------------
default clocking cb @(posedge core_clk_i);
endclocking
default disable iff (!rst_n_i);
// Outputs must already be quiet at the first edge after reset
a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("outputs not idle after reset");
a_last_upper_zero: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    s_axi_araddr_i[4:2] == 3'h4 && s_axi_araddr_i[7:5] < 3'h3 |=> s_axi_rdata_o[31:16] == 16'h0000)
    else $error("last bank upper half not zero");
a_unmapped_err: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:5] == 3'h7
    |=> s_axi_rresp_o == `GFEI_RESP_SLVERR && s_axi_rdata_o == 32'h00000000)
    else $error("unmapped read not refused");
a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer dropped or changed");
a_write_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped or changed");
a_write_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
a_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[1:2] s_axi_bvalid_o)
    else $error("write answer late");
endmodule

bind gfei_top gfei_chk u_chk
(
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .irq_o(irq_o),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i)
);

// [testbench/tb.sv]
// Self-checking bench for the edge interrupt block over its register bus.
// Assumes every task is entered just after a rising clock edge.
`timescale 1ns/1ns
`include "gfei_regs.vh"
module tb;
reg core_clk = 1'b0;
reg rst_n = 1'b0;
reg [143:0] pins = {144{1'b1}};
reg [7:0] aw_addr = 8'h00;
reg aw_valid = 1'b0;
reg [31:0] w_data = 32'h00000000;
reg [3:0] w_strb = 4'h0;
reg w_valid = 1'b0;
reg b_ready = 1'b0;
reg [7:0] ar_addr = 8'h00;
reg ar_valid = 1'b0;
reg r_ready = 1'b0;
reg slow_ready = 1'b0;
wire aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, irq;
wire [1:0] b_resp, r_resp;
wire [31:0] r_data;
int failures = 0;
int compares = 0;
int cycles = 0;
gfei_top dut
(
    .core_clk_i(core_clk), .rst_n_i(rst_n), .gpio_pins_i(pins),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
    .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid),
    .s_axi_rready_i(r_ready), .irq_o(irq)
);
// ----------------------------------------------------------------------------
// Clock, timeout and closing report
// ----------------------------------------------------------------------------
initial
begin
    forever #20 core_clk = ~core_clk;
end
// A hung handshake is cut short here and counted as a mismatch
always @(posedge core_clk)
begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
        failures = failures + 1;
        tally_and_finish;
    end
end
task tally_and_finish;
    begin
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
endtask
// ----------------------------------------------------------------------------
// Bus tasks
// ----------------------------------------------------------------------------
task automatic chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    end
endtask
// Address and data are offered together; each is dropped once taken
task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg aw_ok, w_ok;
    begin
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk);
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= d;
        w_strb <= s;
        w_valid <= 1'b1;
        b_ready <= !slow_ready;
        while (!(aw_ok && w_ok))
        begin
            @(posedge core_clk);
            if (aw_valid && aw_rdy === 1'b1)
            begin
                aw_ok = 1'b1;
                aw_valid <= 1'b0;
            end
            if (w_valid && w_rdy === 1'b1)
            begin
                w_ok = 1'b1;
                w_valid <= 1'b0;
            end
        end
        // A slow master leaves the answer waiting four edges, then raises ready and takes it one edge later
        if (slow_ready)
        begin
            repeat (4) @(posedge core_clk);
            chk("bvalid held", {31'h0, b_valid}, 32'h1);
            b_ready <= 1'b1;
            @(posedge core_clk);
        end
        while (b_valid !== 1'b1)
            @(posedge core_clk);
        b_ready <= 1'b0;
        chk("bresp", {30'h0, b_resp}, {30'h0, er});
    end
endtask
task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
        @(posedge core_clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= !slow_ready;
        do @(posedge core_clk); while (ar_rdy !== 1'b1);
        ar_valid <= 1'b0;
        if (slow_ready)
        begin
            repeat (4) @(posedge core_clk);
            chk("rvalid held", {31'h0, r_valid}, 32'h1);
            r_ready <= 1'b1;
            @(posedge core_clk);
        end
        while (r_valid !== 1'b1)
            @(posedge core_clk);
        d = r_data;
        r = r_resp;
        r_ready <= 1'b0;
    end
endtask
task automatic rdc(input string what, input [7:0] a, input [31:0] exp);
    reg [31:0] d;
    reg [1:0] r;
    begin
        rd(a, d, r);
        chk(what, d, exp);
        chk("rresp", {30'h0, r}, {30'h0, `GFEI_RESP_OKAY});
    end
endtask
task automatic wrc(input [7:0] a, input [31:0] d);
    begin
        wr(a, d, 4'hf, `GFEI_RESP_OKAY);
    end
endtask
// ----------------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------------
task automatic t_reset;
    begin
        for (int w = 0; w < 5; w++)
        begin
            rdc("fall set", 8'(w * 4), 32'h0);
            rdc("fall clear", 8'(8'h20 + w * 4), 32'h0);
            rdc("pending", 8'(8'h40 + w * 4), 32'h0);
        end
        chk("irq", {31'h0, irq}, 32'h0);
    end
endtask
// Set, zero write, partial clear, and the half-width last word
task automatic t_enables;
    reg [31:0] m;
    begin
        for (int w = 0; w < 5; w++)
        begin
            m = (w == 4) ? `GFEI_LAST_WORD_MASK : `GFEI_FULL_WORD_MASK;
            wrc(8'(w * 4), 32'ha5a50f0f);
            wrc(8'(w * 4), 32'h0);
            rdc("set read", 8'(w * 4), 32'ha5a50f0f & m);
            wrc(8'(8'h20 + w * 4), 32'h00000f00);
            rdc("clear read", 8'(8'h20 + w * 4), 32'ha5a5000f & m);
            wrc(8'(8'h20 + w * 4), 32'hffffffff);
            rdc("all off", 8'(w * 4), 32'h0);
        end
        wr(8'h04, 32'hffffffff, 4'h2, `GFEI_RESP_OKAY);
        rdc("strobe", 8'h24, 32'h0000ff00);
        wrc(8'h24, 32'hffffffff);
    end
endtask
task automatic t_edges;
    begin
        wrc(8'h00, 32'h00080000);
        wrc(8'h10, 32'h00008000);
        pins[19] <= 1'b0;
        pins[20] <= 1'b0;
        pins[143] <= 1'b0;
        repeat (8) @(posedge core_clk);
        rdc("fall pend", 8'h40, 32'h00080000);
        rdc("bank8 pend", 8'h50, 32'h00008000);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wrc(8'ha0, 32'h00080000);
        repeat (2) @(posedge core_clk);
        chk("irq on", {31'h0, irq}, 32'h1);
        wrc(8'h40, 32'h0);
        rdc("zero write", 8'h40, 32'h00080000);
        wrc(8'h40, 32'h00080000);
        rdc("one write", 8'h40, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("irq off", {31'h0, irq}, 32'h0);
        // Rising edge is ignored until its own enable is set
        pins[19] <= 1'b1;
        repeat (8) @(posedge core_clk);
        rdc("rise off", 8'h40, 32'h0);
        wrc(8'h60, 32'h00080000);
        wrc(8'h20, 32'h00080000);
        pins[19] <= 1'b0;
        repeat (8) @(posedge core_clk);
        rdc("fall disabled", 8'h40, 32'h0);
        pins[19] <= 1'b1;
        repeat (8) @(posedge core_clk);
        rdc("rise pend", 8'h40, 32'h00080000);
        chk("irq rise", {31'h0, irq}, 32'h1);
        wrc(8'ha0, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("irq disabled", {31'h0, irq}, 32'h0);
        wrc(8'hc0, 32'h00080000);
        rdc("alias clear", 8'h40, 32'h0);
        wrc(8'h50, 32'h00008000);
        rdc("bank8 clear", 8'h50, 32'h0);
        // The rising edge lands on the very edge at which the clear applies
        pins[19] <= 1'b0;
        repeat (8) @(posedge core_clk);
        pins[19] <= 1'b1;
        wrc(8'h40, 32'h00080000);
        rdc("set wins", 8'h40, 32'h00080000);
        wrc(8'h80, 32'h00080000);
        rdc("rise cleared", 8'h60, 32'h0);
    end
endtask
// Answers must stand while the master is not ready
task automatic t_slow_ready;
    begin
        slow_ready = 1'b1;
        wrc(8'ha0, 32'h00001234);
        rdc("slow read", 8'ha0, 32'h00001234);
        slow_ready = 1'b0;
        wrc(8'ha0, 32'h0);
    end
endtask
task automatic t_unmapped;
    reg [31:0] d;
    reg [1:0] r;
    begin
        wr(8'he0, 32'hffffffff, 4'hf, `GFEI_RESP_SLVERR);
        rd(8'h14, d, r);
        chk("unmapped resp", {30'h0, r}, {30'h0, `GFEI_RESP_SLVERR});
        chk("unmapped data", d, 32'h0);
        rd(8'he0, d, r);
        chk("unmapped group resp", {30'h0, r}, {30'h0, `GFEI_RESP_SLVERR});
        chk("unmapped group data", d, 32'h0);
    end
endtask
initial
begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_enables;
    t_edges;
    t_slow_ready;
    t_unmapped;
    tally_and_finish;
end
endmodule
